// [hdl/cpt_ctrl_port.sv]
// I2C/SPI slave control port with memory request buffer
`timescale 1ns/1ps
`include "cpt_defines.svh"
module cpt_ctrl_port (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_power_down_pin_n,
   input wire logic i_scl_sclk,
   input wire logic i_sda_miso,
   input wire logic i_bus_id_strap_hi,
   input wire logic i_bus_id_strap_lo,
   input wire logic i_sda_drive_strong,
   input wire logic i_req_ready,
   input wire logic i_rsp_valid,
   input wire logic [31:0] i_rsp_data,
   output logic o_sda_miso,
   output logic o_sda_miso_oe,
   output logic o_sda_drive_strong,
   output logic o_spi_mode,
   output logic o_req_valid,
   output cpt_pkg::cpt_req_type o_req
);
   // pin bits: 0 scl/sclk, 1 sda, 2 strap hi/mosi, 3 strap lo/select, 4 power down
   logic [4:0] pin_raw;
   logic [4:0] pin_s1;
   logic [4:0] pin_s2;
   logic [4:0] pin_s3;
   logic [4:0] pin_f;
   logic [4:0] pin_q;
   logic [1:0] ss_cnt;
   cpt_pkg::cpt_state_type st;
   logic [3:0] bit_cnt;
   logic [2:0] byte_cnt;
   logic [7:0] sh;
   logic rw;
   logic ack_ok;
   logic rd_phase;
   logic mack;
   logic [31:0] sub;
   logic [31:0] wdata;
   logic [1:0] wn;
   logic [31:0] txw;
   logic [4:0] tx_n;
   logic [31:0] pend_word;
   logic pq_v;
   cpt_pkg::cpt_req_type pq;
   cpt_pkg::cpt_req_type pq_in;
   logic skid_v;
   cpt_pkg::cpt_req_type skid;
   logic scl_rise;
   logic scl_fall;
   logic i2c_start;
   logic i2c_stop;
   logic ss_rise;
   logic ss_fall;
   logic rx_bit;
   logic active;
   logic smp;
   logic shf;
   logic byte_done;
   logic [7:0] rx_byte;
   logic [2:0] data0;
   logic own_hit;
   logic restart;
   logic abort;
   logic tx_go;
   logic tx_bit;
   logic data_byte;
   logic wr_load;
   logic rd_first;
   logic rd_next;
   logic [31:0] rd_addr;
   logic rd_load;
   logic buf_in_ready;
   logic pop;

   function automatic logic addr_ok(input logic [31:0] a);
      addr_ok = (a >= `CPT_CPU_LO && a <= `CPT_CPU_HI) ||
         (a >= `CPT_L2_LO && a <= `CPT_L2_HI) ||
         (a >= `CPT_L2NC_LO && a <= `CPT_L2NC_HI) ||
         (a >= `CPT_FLASH_LO && a <= `CPT_FLASH_HI) ||
         (a >= `CPT_CREG_LO && a <= `CPT_CREG_HI) ||
         (a >= `CPT_PARAM_LO && a <= `CPT_PROG_HI && addr_low_latency(a)) ||
         (a >= `CPT_ABUS_LO && a <= `CPT_ABUS_HI);
   endfunction : addr_ok

   // the three low-latency dsp memories
   function automatic logic addr_low_latency(input logic [31:0] a);
      addr_low_latency = (a >= `CPT_PARAM_LO && a <= `CPT_PARAM_HI) ||
         (a >= `CPT_STATE_LO && a <= `CPT_STATE_HI) ||
         (a >= `CPT_PROG_LO && a <= `CPT_PROG_HI);
   endfunction : addr_low_latency

   // word-addressed dsp memories step by one, byte-addressed by four
   function automatic logic [31:0] addr_step(input logic [31:0] a);
      addr_step = addr_low_latency(a) ? `CPT_STEP_UNIT : `CPT_STEP_WORD;
   endfunction : addr_step

   // one set of pins, meaning chosen by the mode flag
   assign pin_raw = {i_power_down_pin_n, i_bus_id_strap_lo, i_bus_id_strap_hi,
      i_sda_miso, i_scl_sclk};

   // three-stage sync; a level counts once stages two and three agree
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pin_s1 <= 5'h1f;
         pin_s2 <= 5'h1f;
         pin_s3 <= 5'h1f;
         pin_f <= 5'h1f;
         pin_q <= 5'h1f;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
         pin_q <= pin_f;
      end
   end

   // edges of the filtered levels; the host owns the clock
   // clock only sampled
   assign scl_rise = pin_f[0] & ~pin_q[0];
   assign scl_fall = ~pin_f[0] & pin_q[0];
   assign ss_rise = pin_f[3] & ~pin_q[3];
   assign ss_fall = ~pin_f[3] & pin_q[3];
   assign i2c_start = ~o_spi_mode & pin_q[0] & pin_f[0] & pin_q[1] & ~pin_f[1];
   assign i2c_stop = ~o_spi_mode & pin_q[0] & pin_f[0] & ~pin_q[1] & pin_f[1];
   assign restart = o_spi_mode ? ss_fall : i2c_start;
   assign abort = o_spi_mode ? pin_f[3] : i2c_stop;

   // both modes sample on rising and drive on falling clock
   assign rx_bit = o_spi_mode ? pin_f[2] : pin_f[1];
   assign active = o_spi_mode ? ~pin_f[3] : (st != cpt_pkg::st_idle);
   assign smp = scl_rise & active;
   assign shf = scl_fall & active;
   assign rx_byte = {sh[6:0], rx_bit};
   assign byte_done = smp && st == cpt_pkg::st_recv && bit_cnt == 4'h7;
   // fixed upper bits above the two straps
   assign own_hit = rx_byte[7:1] == {`CPT_I2C_ADDR_HI, pin_f[2], pin_f[3]};
   // spi data follows the dummy byte
   assign data0 = o_spi_mode ? `CPT_SPI_DATA0 : `CPT_I2C_DATA0;
   assign data_byte = byte_done && byte_cnt >= data0 && ~rw;

   // count whole select pulses while in I2C mode
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || ~pin_f[4]) begin
         // only reset or power down leaves SPI mode
         o_spi_mode <= 1'b0;
         ss_cnt <= 2'h0;
      end else if (~o_spi_mode && ss_rise) begin
         ss_cnt <= ss_cnt + 2'h1;
         if (ss_cnt + 2'h1 == `CPT_SPI_PULSES) begin
            o_spi_mode <= 1'b1;
         end
      end
   end

   // which falling edge puts a read bit on the pin
   assign tx_go = shf && ((st == cpt_pkg::st_send && (bit_cnt != `CPT_BIT_LAST || o_spi_mode))
      || (st == cpt_pkg::st_acko && rd_phase) || (st == cpt_pkg::st_acki && mack)
      || (st == cpt_pkg::st_recv && bit_cnt == `CPT_BIT_LAST && o_spi_mode && rd_phase));
   assign tx_bit = (tx_n == 5'h00) ? pend_word[31] : txw[31];

   // bit-level sequencer
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st <= cpt_pkg::st_idle;
         bit_cnt <= 4'h0;
         sh <= 8'h00;
         mack <= 1'b0;
      end else if (abort) begin
         // stop or deselect ends even a half-read word
         st <= cpt_pkg::st_idle;
         bit_cnt <= 4'h0;
      end else if (restart) begin
         st <= cpt_pkg::st_recv;
         bit_cnt <= 4'h0;
      end else begin
         case (st)
            cpt_pkg::st_recv: begin
               if (smp) begin
                  sh <= rx_byte;
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (shf && bit_cnt == `CPT_BIT_LAST) begin
                  bit_cnt <= 4'h0;
                  if (o_spi_mode) begin
                     st <= rd_phase ? cpt_pkg::st_send : cpt_pkg::st_recv;
                  end else begin
                     st <= ack_ok ? cpt_pkg::st_acko : cpt_pkg::st_idle;
                  end
               end
            end
            cpt_pkg::st_acko: begin
               if (shf) begin
                  bit_cnt <= 4'h0;
                  st <= rd_phase ? cpt_pkg::st_send : cpt_pkg::st_recv;
               end
            end
            cpt_pkg::st_send: begin
               if (smp) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (shf && bit_cnt == `CPT_BIT_LAST) begin
                  bit_cnt <= 4'h0;
                  st <= o_spi_mode ? cpt_pkg::st_send : cpt_pkg::st_acki;
               end
            end
            cpt_pkg::st_acki: begin
               if (smp) begin
                  mack <= ~rx_bit;
               end else if (shf) begin
                  // host nack ends the burst read
                  st <= mack ? cpt_pkg::st_send : cpt_pkg::st_idle;
               end
            end
            default: begin
               st <= cpt_pkg::st_idle;
            end
         endcase
      end
   end

   // byte-level fields: direction, sub-address, write word
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         byte_cnt <= 3'h0;
         rw <= 1'b0;
         ack_ok <= 1'b0;
         rd_phase <= 1'b0;
         sub <= 32'h0000_0000;
         wdata <= 32'h0000_0000;
         wn <= 2'h0;
      end else if (restart) begin
         byte_cnt <= 3'h0;
         wn <= 2'h0;
         rd_phase <= 1'b0;
      end else if (byte_done) begin
         if (byte_cnt != `CPT_BYTE_SAT) begin
            byte_cnt <= byte_cnt + 3'h1;
         end
         if (byte_cnt == 3'h0) begin
            rw <= rx_byte[0];
            ack_ok <= o_spi_mode | own_hit;
            rd_phase <= ~o_spi_mode & own_hit & rx_byte[0];
         end else if (byte_cnt <= `CPT_SUB_LAST) begin
            sub <= {sub[23:0], rx_byte};
         end else if (o_spi_mode && byte_cnt == `CPT_SPI_DUMMY) begin
            // dummy byte, then read data starts
            rd_phase <= rw;
         end
         if (data_byte) begin
            wdata <= {wdata[23:0], rx_byte};
            wn <= wn + 2'h1;
            if (wn == 2'h3) begin
               sub <= sub + addr_step(sub);
            end
         end
      end else if (rd_next) begin
         sub <= sub + addr_step(sub);
      end
   end

   // only a whole word to a mapped place is stored
   assign wr_load = data_byte && wn == 2'h3 && addr_ok(sub);
   assign rd_first = byte_done && ((~o_spi_mode && byte_cnt == 3'h0 && own_hit && rx_byte[0])
      || (o_spi_mode && byte_cnt == `CPT_SUB_LAST && rw));
   // next word fetched while the last byte of this one goes out
   assign rd_next = tx_go && tx_n == `CPT_TX_PREFETCH;
   assign rd_addr = rd_first ? (o_spi_mode ? {sub[23:0], rx_byte} : sub)
      : sub + addr_step(sub);
   assign rd_load = (rd_first | rd_next) && addr_ok(rd_addr);
   assign pq_in = wr_load ? {1'b1, sub, wdata[23:0], rx_byte} : {1'b0, rd_addr, 32'h0000_0000};

   // read word waiting to be shifted out
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pend_word <= 32'h0000_0000;
      end else if ((rd_first | rd_next) && ~rd_load) begin
         pend_word <= 32'h0000_0000;
      end else if (i_rsp_valid) begin
         pend_word <= i_rsp_data;
      end
   end

   // read shifter: 32 bits per word, msb first
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         txw <= 32'h0000_0000;
         tx_n <= 5'h00;
      end else if (restart) begin
         tx_n <= 5'h00;
      end else if (tx_go) begin
         tx_n <= tx_n + 5'h01;
         txw <= (tx_n == 5'h00) ? {pend_word[30:0], 1'b0} : {txw[30:0], 1'b0};
      end
   end

   // data pin: open-drain in I2C, driven MISO in SPI
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_sda_miso <= 1'b0;
         o_sda_miso_oe <= 1'b0;
      end else if (o_spi_mode) begin
         // released except while returning read data
         if (pin_f[3]) begin
            o_sda_miso_oe <= 1'b0;
         end else if (tx_go) begin
            o_sda_miso_oe <= 1'b1;
            o_sda_miso <= tx_bit;
         end
      end else begin
         o_sda_miso <= 1'b0;
         if (i2c_start | i2c_stop) begin
            o_sda_miso_oe <= 1'b0;
         end else if (tx_go) begin
            o_sda_miso_oe <= ~tx_bit;
         end else if (shf && st == cpt_pkg::st_recv && bit_cnt == `CPT_BIT_LAST) begin
            // pull low on the ninth pulse only when the address was acked
            o_sda_miso_oe <= ack_ok;
         end else if (shf) begin
            o_sda_miso_oe <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_sda_drive_strong <= 1'b0;
      end else begin
         o_sda_drive_strong <= i_sda_drive_strong;
      end
   end

   // staging slot: holds a request until the buffer takes it
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pq_v <= 1'b0;
         pq <= '0;
      end else if (wr_load | rd_load) begin
         pq_v <= 1'b1;
         pq <= pq_in;
      end else if (buf_in_ready) begin
         pq_v <= 1'b0;
      end
   end

   // two-entry buffer: head drives the ports, skid catches a stall
   assign buf_in_ready = ~o_req_valid | pop | ~skid_v;
   assign pop = o_req_valid & i_req_ready;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_req_valid <= 1'b0;
         o_req <= '0;
         skid_v <= 1'b0;
         skid <= '0;
      end else if (~o_req_valid || (pop && ~skid_v)) begin
         o_req_valid <= pq_v;
         o_req <= pq;
      end else if (pop) begin
         o_req <= skid;
         skid_v <= pq_v;
         skid <= pq;
      end else if (pq_v && ~skid_v) begin
         skid_v <= 1'b1;
         skid <= pq;
      end
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   property p_third_pulse;
      $rose(o_spi_mode) |-> $past(ss_cnt) == 2'h2 && $past(ss_rise);
   endproperty
   a_third_pulse: assert property (p_third_pulse) else $error("spi mode not on third pulse");

   property p_pd_exit;
      $fell(o_spi_mode) |-> $past(~pin_f[4]);
   endproperty
   a_pd_exit: assert property (p_pd_exit) else $error("spi mode left without power down");

   property p_addr_nack;
      (byte_done && byte_cnt == 3'h0 && ~o_spi_mode && ~own_hit) |=> ~ack_ok;
   endproperty
   a_addr_nack: assert property (p_addr_nack) else $error("foreign address acked");

   property p_ack_low;
      (st == cpt_pkg::st_acko && $past(st) == cpt_pkg::st_acko) |-> o_sda_miso_oe && ~o_sda_miso;
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("ack not driven low");

   property p_stop_idle;
      i2c_stop |=> st == cpt_pkg::st_idle ##1 ~o_sda_miso_oe;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle");

   property p_whole_word;
      (pq_v && ~$past(pq_v) && pq.wr) |-> $past(wn) == 2'h3 && $past(data_byte);
   endproperty
   a_whole_word: assert property (p_whole_word) else $error("partial word written");

   property p_no_bad_write;
      (o_req_valid && o_req.wr) |-> addr_ok(o_req.addr);
   endproperty
   a_no_bad_write: assert property (p_no_bad_write) else $error("write to reserved space");

   property p_miso_release;
      (o_spi_mode && pin_f[3]) |=> ~o_sda_miso_oe;
   endproperty
   a_miso_release: assert property (p_miso_release) else $error("miso driven while deselected");

   property p_hold_req;
      (o_req_valid && ~i_req_ready) |=> o_req_valid && $stable(o_req);
   endproperty
   a_hold_req: assert property (p_hold_req) else $error("request dropped under stall");
endmodule : cpt_ctrl_port

// [hdl/cpt_defines.svh]
// control port constants: address map, strap address, framing counts
// Functional notes
// - I2C after reset; SPI after three selects
// - straps give low address bits, 0x28-0x2B
// - shared pins remap between I2C and SPI
// - address byte, four sub-address bytes, data
// - first byte bit 0: 1 read, 0 write
// - reserved locations read back as zero
// - burst advances sub-address until stop or deselect
// - step size follows destination region word size
// - decoder accepts mapped regions, rest reserved
// - write lands only after four whole bytes
// - read may end before word completes
// - most significant byte travels first
// - I2C up to 1MHz, strong drive bit
// - idle slave detects start, shifts address MSB-first
// - ack own address on ninth pulse, else idle
// - SDA rising with SCL high is stop
// - stray start or stop drops transaction at once
// - invalid sub-address: ack, no write, zero read
// - burst write beyond top is discarded
// - SPI: command, four address bytes, zero dummy
// - SPI sample rising, drive falling, else released
// - leave SPI only through power-down pin
`ifndef CPT_DEFINES_SVH
`define CPT_DEFINES_SVH
`define CPT_I2C_ADDR_HI 5'h0a
`define CPT_SPI_PULSES 2'h3
`define CPT_SUB_LAST 3'h4
`define CPT_SPI_DUMMY 3'h5
`define CPT_I2C_DATA0 3'h5
`define CPT_SPI_DATA0 3'h6
`define CPT_BYTE_SAT 3'h7
`define CPT_BIT_LAST 4'h8
`define CPT_TX_PREFETCH 5'h18
`define CPT_STEP_WORD 32'h0000_0004
`define CPT_STEP_UNIT 32'h0000_0001
`define CPT_CPU_LO 32'h0002_0000
`define CPT_CPU_HI 32'h0007_ffff
`define CPT_L2_LO 32'h1000_0000
`define CPT_L2_HI 32'h1009_ffff
`define CPT_L2NC_LO 32'h2000_0000
`define CPT_L2NC_HI 32'h2009_ffff
`define CPT_FLASH_LO 32'h4000_0000
`define CPT_FLASH_HI 32'h4fff_ffff
`define CPT_CREG_LO 32'hf000_0000
`define CPT_CREG_HI 32'hf000_11fc
`define CPT_PARAM_LO 32'hf002_0000
`define CPT_PARAM_HI 32'hf002_077f
`define CPT_STATE_LO 32'hf003_0000
`define CPT_STATE_HI 32'hf003_01ff
`define CPT_PROG_LO 32'hf004_0000
`define CPT_PROG_HI 32'hf004_007f
`define CPT_ABUS_LO 32'hf005_0000
`define CPT_ABUS_HI 32'hf005_01ff
`endif

// [hdl/cpt_pkg.sv]
// control port types: engine states and memory request word
package cpt_pkg;
   // gray along idle, receive, ack out, send, ack in
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_recv = 3'b001,
      st_acko = 3'b011,
      st_send = 3'b010,
      st_acki = 3'b110
   } cpt_state_type;

   // one memory access handed to the fabric
   typedef struct packed {
      logic wr;
      logic [31:0] addr;
      logic [31:0] data;
   } cpt_req_type;
endpackage : cpt_pkg

// [test/cpt_ctrl_port_test.sv]
// bench for the control port: host pins, memory fabric and checks
`timescale 1ns/1ps
module cpt_ctrl_port_test;
   typedef struct packed {
      logic hi;
      logic lo;
      logic [6:0] dev;
      logic [31:0] sub;
      logic [31:0] d;
      logic [3:0] nb;
      logic ack;
      logic wr;
   } cpt_row_type;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic i_power_down_pin_n = 1'b1;
   logic i_sda_drive_strong = 1'b0;
   logic i_req_ready = 1'b0;
   logic i_rsp_valid = 1'b0;
   logic [31:0] i_rsp_data = 32'h0;
   logic o_sda_miso, o_sda_miso_oe, o_sda_drive_strong, o_spi_mode, o_req_valid;
   cpt_pkg::cpt_req_type o_req;
   logic scl, sda_low, mosi, ss_n, sda, ok, stall = 1'b0;
   logic [63:0] wq[$];
   logic [31:0] rd_addr = 32'h0;
   int rd_wait = 0;
   int cycles = 0;
   int miscompares = 0;
   int num_checks = 0;
   // ordinary cases: straps, device address, sub-address, data, bytes, ack, write
   cpt_row_type rows[6] = '{
      '{1'b1, 1'b1, 7'h2b, 32'h0002_0000, 32'h1122_3344, 4'h4, 1'b1, 1'b1},
      '{1'b0, 1'b1, 7'h29, 32'hf000_11fc, 32'h8899_aabb, 4'h4, 1'b1, 1'b1},
      '{1'b0, 1'b1, 7'h2b, 32'h0002_0000, 32'h5566_7788, 4'h4, 1'b0, 1'b0},
      '{1'b1, 1'b0, 7'h2a, 32'h4000_0010, 32'h0bad_0001, 4'h4, 1'b1, 1'b1},
      '{1'b0, 1'b0, 7'h28, 32'h5000_0000, 32'h0bad_0002, 4'h4, 1'b1, 1'b0},
      '{1'b0, 1'b0, 7'h28, 32'h2009_fffc, 32'h0bad_0003, 4'h2, 1'b1, 1'b0}};
   always #2.5 i_clk_sys = ~i_clk_sys;
   // open-drain wire with pull-up; in SPI the device drives both levels
   assign sda = !(sda_low || (o_sda_miso_oe && !o_sda_miso));
   cpt_ctrl_port cpt_ctrl_port_inst (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_power_down_pin_n(i_power_down_pin_n),
      .i_scl_sclk(scl), .i_sda_miso(sda), .i_bus_id_strap_hi(mosi),
      .i_bus_id_strap_lo(ss_n), .i_sda_drive_strong(i_sda_drive_strong),
      .i_req_ready(i_req_ready), .i_rsp_valid(i_rsp_valid), .i_rsp_data(i_rsp_data),
      .o_sda_miso(o_sda_miso), .o_sda_miso_oe(o_sda_miso_oe),
      .o_sda_drive_strong(o_sda_drive_strong), .o_spi_mode(o_spi_mode),
      .o_req_valid(o_req_valid), .o_req(o_req));
   cpt_host_model cpt_host_model_inst (
      .i_clk(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low), .o_mosi(mosi),
      .o_ss_n(ss_n));
   function automatic logic [31:0] word_of(input logic [31:0] a);
      return {a[15:0], ~a[15:0]};
   endfunction : word_of
   // fabric: take requests on the edge, log writes, answer reads later
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles >= 50000) begin
         miscompares++;
         complete_run();
      end else if (o_req_valid && i_req_ready && o_req.wr)
         wq.push_back({o_req.addr, o_req.data});
      else if (o_req_valid && i_req_ready) begin
         rd_addr = o_req.addr;
         rd_wait = 4;
      end
   end
   // fabric outputs change on the falling edge only
   always @(negedge i_clk_sys) begin
      i_req_ready <= !stall;
      i_rsp_valid <= rd_wait == 1;
      i_rsp_data <= word_of(rd_addr);
      if (rd_wait > 0)
         rd_wait--;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run;
      $display("checks=%0d mismatches=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   // drain the write log and compare each word in order
   task automatic expect_writes(input logic [31:0] sub, input logic [31:0] step,
                                input logic [31:0] d, input int n);
      repeat (20) @(negedge i_clk_sys);
      chk(64'(wq.size()), 64'(n));
      for (int k = 0; k < n && wq.size() > 0; k++)
         chk(wq.pop_front(), {sub + step * 32'(k), d + 32'(k)});
   endtask : expect_writes
   // device byte, four sub-address bytes, then nb data bytes; rs skips the stop
   task automatic i2c_wr(input logic [6:0] dev, input logic [31:0] sub,
                         input logic [31:0] d, input int nb, input logic rs,
                         output logic ack);
      logic [7:0] rx;
      logic a;
      logic [31:0] w;
      cpt_host_model_inst.start();
      cpt_host_model_inst.i2c_byte({dev, 1'b0}, 1'b0, rx, ack);
      for (int j = 0; j < nb + 4 && ack; j++) begin
         w = (j < 4) ? sub : d + 32'((j - 4) / 4);
         cpt_host_model_inst.i2c_byte(w[31 - 8 * (j % 4) -: 8], 1'b0, rx, a);
         ack = ack & a;
      end
      if (!rs)
         cpt_host_model_inst.stop();
   endtask : i2c_wr
   // sub-address write, repeated start, nb bytes, nack, stop
   task automatic i2c_rd(input logic [31:0] sub, input logic [31:0] step, input int nb,
                         input logic zero);
      logic [7:0] rx;
      logic a;
      logic [31:0] w;
      logic [31:0] e;
      i2c_wr(7'h28, sub, 32'h0, 0, 1'b1, a);
      chk(64'(a), 64'h1);
      cpt_host_model_inst.start();
      cpt_host_model_inst.i2c_byte({7'h28, 1'b1}, 1'b0, rx, a);
      chk(64'(a), 64'h1);
      for (int j = 0; j < nb; j++) begin
         cpt_host_model_inst.i2c_byte(8'hff, j < nb - 1, rx, a);
         w = (j % 4 == 0) ? 32'(rx) : {w[23:0], rx};
         e = zero ? 32'h0 : word_of(sub + step * 32'(j / 4));
         chk(64'(w), 64'(e >> (8 * (3 - j % 4))));
      end
      cpt_host_model_inst.stop();
   endtask : i2c_rd
   // command, sub-address, zero dummy byte, one data word
   task automatic spi_tx(input logic rd, input logic [31:0] sub, input logic [31:0] d);
      logic [7:0] b;
      logic [7:0] rx;
      logic [31:0] w;
      cpt_host_model_inst.spi_open();
      for (int j = 0; j < 10; j++) begin
         b = j == 0 ? {7'h0, rd} : j < 5 ? sub[39 - 8 * j -: 8] :
             j == 5 ? 8'h0 : d[79 - 8 * j -: 8];
         if (j == 5)
            chk(64'(o_sda_miso_oe), 64'h0);
         cpt_host_model_inst.spi_byte(b, rx);
         w = {w[23:0], rx};
      end
      cpt_host_model_inst.spi_close();
      if (rd)
         chk(64'(w), 64'(word_of(sub)));
   endtask : spi_tx
   // main sequence: reset, table, then the awkward cases
   initial begin
      logic [7:0] rx;
      repeat (20) @(negedge i_clk_sys);
      i_rst = 1'b0;
      repeat (6) @(negedge i_clk_sys);
      chk(64'({o_sda_miso, o_sda_miso_oe, o_spi_mode, o_req_valid}), 64'h0);
      chk({o_req.addr, o_req.data}, 64'h0);
      i_sda_drive_strong = 1'b1;
      repeat (3) @(negedge i_clk_sys);
      chk(64'(o_sda_drive_strong), 64'h1);
      $display("reset test done");
      foreach (rows[k]) begin
         cpt_host_model_inst.set_id(rows[k].hi, rows[k].lo);
         i2c_wr(rows[k].dev, rows[k].sub, rows[k].d, int'(rows[k].nb), 1'b0, ok);
         chk(64'(ok), 64'(rows[k].ack));
         expect_writes(rows[k].sub, 32'h4, rows[k].d, int'(rows[k].wr));
         $display("row %0d done", k);
      end
      // a stop inside the sub-address drops the header
      cpt_host_model_inst.start();
      cpt_host_model_inst.i2c_byte(8'h50, 1'b0, rx, ok);
      cpt_host_model_inst.i2c_byte(8'hf0, 1'b0, rx, ok);
      cpt_host_model_inst.stop();
      i2c_wr(7'h28, 32'h0002_0010, 32'h0102_0304, 4, 1'b0, ok);
      expect_writes(32'h0002_0010, 32'h4, 32'h0102_0304, 1);
      $display("stray stop test done");
      // buffered burst while the fabric stalls, with a slower host clock
      cpt_host_model_inst.q = 24.0;
      stall <= 1'b1;
      i2c_wr(7'h28, 32'h1000_0000, 32'ha000_0000, 12, 1'b0, ok);
      chk(64'({o_req_valid, 1'(wq.size())}), 64'h2);
      stall <= 1'b0;
      expect_writes(32'h1000_0000, 32'h4, 32'ha000_0000, 3);
      cpt_host_model_inst.q = 16.0;
      i2c_wr(7'h28, 32'hf004_007e, 32'hb000_0000, 12, 1'b0, ok);
      expect_writes(32'hf004_007e, 32'h1, 32'hb000_0000, 2);
      $display("burst test done");
      i2c_rd(32'hf002_0000, 32'h1, 8, 1'b0);
      i2c_rd(32'h1000_0100, 32'h4, 6, 1'b0);
      i2c_rd(32'h5000_0000, 32'h4, 4, 1'b1);
      expect_writes(32'h0, 32'h0, 32'h0, 0);
      $display("read test done");
      // clear the pulse count, then two pulses keep I2C and the third switches
      cpt_host_model_inst.set_id(1'b0, 1'b1);
      repeat (10) @(negedge i_clk_sys);
      i_power_down_pin_n = 1'b0;
      repeat (10) @(negedge i_clk_sys);
      i_power_down_pin_n = 1'b1;
      for (int p = 0; p < 4; p++) begin
         repeat (10) @(negedge i_clk_sys);
         chk(64'(o_spi_mode), 64'(p == 3));
         if (p < 3)
            cpt_host_model_inst.select_pulse();
      end
      spi_tx(1'b0, 32'hf005_0000, 32'hcafe_f00d);
      expect_writes(32'hf005_0000, 32'h4, 32'hcafe_f00d, 1);
      spi_tx(1'b1, 32'h0006_0010, 32'h0);
      chk(64'(o_spi_mode), 64'h1);
      i_power_down_pin_n = 1'b0;
      repeat (10) @(negedge i_clk_sys);
      chk(64'(o_spi_mode), 64'h0);
      i_power_down_pin_n = 1'b1;
      cpt_host_model_inst.set_id(1'b0, 1'b1);
      i2c_wr(7'h29, 32'h0002_0004, 32'h0a0b_0c0d, 4, 1'b0, ok);
      expect_writes(32'h0002_0004, 32'h4, 32'h0a0b_0c0d, 1);
      $display("mode test done");
      complete_run();
   end
endmodule : cpt_ctrl_port_test

// [test/cpt_host_model.sv]
// host master model: drives the shared clock, data, strap and select pins
`timescale 1ns/1ps
module cpt_host_model (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low,
   output logic o_mosi,
   output logic o_ss_n
);
   realtime q = 16.0; // quarter of the 64 ns link clock; raise it for a slow host
   // the host owns the serial clock; pins start idle
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
      o_mosi = 1'b0;
      o_ss_n = 1'b1;
   end
   // strap levels while in I2C mode
   task automatic set_id(input logic hi, input logic lo);
      o_mosi = hi;
      o_ss_n = lo;
   endtask : set_id
   // one start per clock-high phase; offset keeps pin edges off clk edges
   task automatic start;
      @(negedge i_clk);
      #(q + 0.7) o_sda_low = 1'b0;
      #q o_scl = 1'b1;
      #q o_sda_low = 1'b1;
      #q o_scl = 1'b0;
   endtask : start
   task automatic stop;
      #q o_sda_low = 1'b1;
      #q o_scl = 1'b1;
      #q o_sda_low = 1'b0;
      #q;
   endtask : stop
   // msb first; the ninth clock carries the acknowledge
   task automatic i2c_byte(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack);
      logic [8:0] s;
      for (int i = 8; i >= 0; i--) begin
         #q o_sda_low = (i > 0) ? !tx[i - 1] : ack_in;
         #q o_scl = 1'b1;
         #q s = {s[7:0], i_sda};
         #q o_scl = 1'b0;
      end
      rx = s[8:1];
      ack = !s[0];
   endtask : i2c_byte
   // data set while the clock is low, read back on the rising edge
   task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_mosi = tx[i];
         #(2 * q) o_scl = 1'b1;
         rx[i] = i_sda;
         #(2 * q) o_scl = 1'b0;
      end
   endtask : spi_byte
   // select frames each transaction; the clock rests low around it
   task automatic spi_open;
      o_scl = 1'b0;
      @(negedge i_clk);
      #(q + 0.7) o_ss_n = 1'b0;
   endtask : spi_open
   task automatic spi_close;
      #(2 * q) o_ss_n = 1'b1;
      o_mosi = !o_mosi; // released input must not hold a stale level
   endtask : spi_close
   // one low pulse on the select pin, high again between pulses
   task automatic select_pulse;
      #(4 * q) o_ss_n = 1'b0;
      #(4 * q) o_ss_n = 1'b1;
   endtask : select_pulse
endmodule : cpt_host_model
